// File: include/timer_pkg.sv
// constants, codes and helpers shared by the timer compare and waveform block
package timer_pkg;

  // ------------------------------------------------------------------
  // register byte addresses (one aligned word each, data in bits 7:0)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0c;
  localparam logic [7:0] OFS_CA_LO = 8'h10;
  localparam logic [7:0] OFS_CA_HI = 8'h14;
  localparam logic [7:0] OFS_CP = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1c;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int EN_BIT = 3;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int ACT_HI = 5;
  localparam int ACT_LO = 4;
  localparam int OCL_BIT = 3;
  localparam int INV_BIT = 2;
  localparam int SWAP_BIT = 1;
  localparam int CSEL_BIT = 0;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ------------------------------------------------------------------
  // mode and pin action codes
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_CM = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TC = 2'h3;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOG = 2'h3;
  localparam logic [1:0] ACT_INACT = 2'h0;
  localparam logic [1:0] ACT_ACT = 2'h1;
  localparam logic [1:0] ACT_PWM = 2'h2;

  // ------------------------------------------------------------------
  // bus and arithmetic constants
  // ------------------------------------------------------------------
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [16:0] FULL_SPAN = 17'h10000;
  localparam logic [7:0] LOW_ZERO = 8'h00;

  // compare-p value in timer clocks: n*256, or the full 16-bit span for zero
  function automatic logic [16:0] scaled_p(input logic [7:0] cp);
    scaled_p = (cp == RST_BYTE) ? FULL_SPAN : {1'b0, cp, LOW_ZERO};
  endfunction

endpackage

// File: include/timer_if.sv
// signals between the register side and the counter core
`timescale 1ns/100ps
`default_nettype none
interface timer_if;
  logic en;
  logic rise;
  logic clr_a;
  logic [15:0] ca;
  logic [7:0] cp;
  logic [15:0] cnt;
  logic match_a;
  logic match_p;
  modport ctl(output en, rise, clr_a, ca, cp, input cnt, match_a, match_p);
  modport core(input en, rise, clr_a, ca, cp, output cnt, match_a, match_p);
endinterface
`default_nettype wire

// File: src/count_core.sv
// 16-bit up counter with comparators a and p and clear selection
`timescale 1ns/100ps
`default_nettype none
module count_core (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register side
  timer_if.core tif
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [16:0] cnt_inc;
  logic clear;

  // next count seen 17 bits wide so that a p match at zero means overflow
  assign cnt_inc = {1'b0, cnt_r} + 17'h00001;
  assign tif.match_p = tif.en && !tif.rise && (cnt_inc == timer_pkg::scaled_p(tif.cp));
  assign tif.match_a = tif.en && !tif.rise && (tif.ca != timer_pkg::RST_WORD) &&
                       (cnt_inc == {1'b0, tif.ca});
  assign clear = tif.clr_a ? tif.match_a : tif.match_p;
  // wrap past ffff is the overflow clear when no match is armed
  assign cnt_nxt = clear ? timer_pkg::RST_WORD : cnt_inc[15:0];
  assign tif.cnt = cnt_r;

  // restart at zero, hold when off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= timer_pkg::RST_WORD;
    end else if (tif.rise) begin
      cnt_r <= timer_pkg::RST_WORD;
    end else if (tif.en) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule
`default_nettype wire

// File: src/timer_cmp_pwm.sv
// timer compare, pwm waveform and ahb-lite register slave
//
// Function
// - compare-a held in two rw bytes
// - compare-p byte matches counter upper byte
// - p match period n*256, zero gives 65536
// - p match or overflow clears when select low
// - compare mode raises both match flags
// - select high: a clears, no p flag
// - compare-a zero: overflow, no a flag
// - compare mode pin follows only a matches
// - action field: high, low, toggle, none
// - enable rise loads pin initial level
// - timer mode counts alike, pin undriven
// - pwm ignores select, swap picks roles
// - pwm raises a flag per comparator
// - pwm level, invert and forced levels
// - swap 0: period p*256, duty a
// - duty at or above period: always active
// - swap 1: period a, duty p*256
// - counting continues while output forced
// - compare action codes 00,01,10,11
// - pwm action codes forced inactive, forced active, pwm (10 and 11)
// - enable rise zeroes counter, fall holds
// - initial level bit meaning per mode
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module timer_cmp_pwm (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // output pin
  output logic timer_output_pin,
  output logic pin_oe_n
);

  // ------------------------------------------------------------------
  // bus phase tracking
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WR = 4'b0010,
    ST_RDW = 4'b0100,
    ST_RDO = 4'b1000
  } bus_state_t;

  bus_state_t state_r;
  bus_state_t state_nxt;
  logic [7:0] addr_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic accept;
  logic wr_commit;

  // a new address phase is only taken while our own ready is high
  assign accept = hsel && hready && htrans[timer_pkg::HTRANS_ACTIVE_BIT] &&
                  (state_r != ST_RDW);
  assign wr_commit = (state_r == ST_WR);

  always_comb begin
    state_nxt = ST_IDLE;
    unique case (state_r)
      ST_IDLE, ST_WR, ST_RDO: begin
        if (accept) begin
          state_nxt = hwrite ? ST_WR : ST_RDW;
        end
      end
      ST_RDW: begin
        state_nxt = ST_RDO;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // reads take one wait state so a write just before is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      hreadyout_r <= 1'b1;
      addr_r <= timer_pkg::RST_BYTE;
    end else begin
      state_r <= state_nxt;
      hreadyout_r <= (state_nxt != ST_RDW);
      if (accept) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------
  logic en_r;
  logic en_d_r;
  logic [7:0] ctrl1_r;
  logic [7:0] ca_lo_r;
  logic [7:0] ca_hi_r;
  logic [7:0] cp_r;
  logic flag_a_r;
  logic flag_p_r;
  logic [7:0] wbyte;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_ca_lo;
  logic wr_ca_hi;
  logic wr_cp;
  logic wr_flags;

  // write decode; unmapped addresses are ignored with an okay answer
  assign wbyte = hwdata[7:0];
  assign wr_ctrl0 = wr_commit && (addr_r == timer_pkg::OFS_CTRL0);
  assign wr_ctrl1 = wr_commit && (addr_r == timer_pkg::OFS_CTRL1);
  assign wr_ca_lo = wr_commit && (addr_r == timer_pkg::OFS_CA_LO);
  assign wr_ca_hi = wr_commit && (addr_r == timer_pkg::OFS_CA_HI);
  assign wr_cp = wr_commit && (addr_r == timer_pkg::OFS_CP);
  assign wr_flags = wr_commit && (addr_r == timer_pkg::OFS_FLAGS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r <= 1'b0;
      ctrl1_r <= timer_pkg::RST_BYTE;
      ca_lo_r <= timer_pkg::RST_BYTE;
      ca_hi_r <= timer_pkg::RST_BYTE;
      cp_r <= timer_pkg::RST_BYTE;
    end else begin
      if (wr_ctrl0) en_r <= wbyte[timer_pkg::EN_BIT];
      if (wr_ctrl1) ctrl1_r <= wbyte;
      if (wr_ca_lo) ca_lo_r <= wbyte;
      if (wr_ca_hi) ca_hi_r <= wbyte;
      if (wr_cp) cp_r <= wbyte;
    end
  end

  // ------------------------------------------------------------------
  // field decode and counter core
  // ------------------------------------------------------------------
  logic [1:0] mode;
  logic [1:0] act;
  logic ocl;
  logic inv;
  logic swap;
  logic csel;
  logic is_cm;
  logic is_pwm;
  logic rise;
  logic [15:0] ca;

  assign mode = ctrl1_r[timer_pkg::MODE_HI:timer_pkg::MODE_LO];
  assign act = ctrl1_r[timer_pkg::ACT_HI:timer_pkg::ACT_LO];
  assign ocl = ctrl1_r[timer_pkg::OCL_BIT];
  assign inv = ctrl1_r[timer_pkg::INV_BIT];
  assign swap = ctrl1_r[timer_pkg::SWAP_BIT];
  assign csel = ctrl1_r[timer_pkg::CSEL_BIT];
  assign is_cm = (mode == timer_pkg::MODE_CM);
  assign is_pwm = (mode == timer_pkg::MODE_PWM);
  assign ca = {ca_hi_r, ca_lo_r};
  // enable edge taken against a delayed copy of the enable bit
  assign rise = en_r && !en_d_r;

  timer_if tif();

  assign tif.en = en_r;
  assign tif.rise = rise;
  assign tif.ca = ca;
  assign tif.cp = cp_r;
  assign tif.clr_a = is_pwm ? swap : csel;

  count_core u_core (
    .hclk(hclk),
    .hresetn(hresetn),
    .tif(tif)
  );

  // ------------------------------------------------------------------
  // match flags
  // ------------------------------------------------------------------
  logic set_a;
  logic set_p;
  logic clr_fa;
  logic clr_fp;

  assign set_a = tif.match_a;
  assign set_p = tif.match_p && (is_pwm || !csel);
  // write one to clear; a match in the same cycle keeps the flag set
  assign clr_fa = wr_flags && wbyte[timer_pkg::FLAG_A_BIT];
  assign clr_fp = wr_flags && wbyte[timer_pkg::FLAG_P_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
      en_d_r <= 1'b0;
    end else begin
      flag_a_r <= set_a || (flag_a_r && !clr_fa);
      flag_p_r <= set_p || (flag_p_r && !clr_fp);
      en_d_r <= en_r;
    end
  end

  // ------------------------------------------------------------------
  // output pin
  // ------------------------------------------------------------------
  logic level_r;
  logic level_nxt;
  logic [16:0] duty;
  logic pwm_on;
  logic pwm_lvl;
  logic pin_r;
  logic pin_nxt;
  logic oe_n_r;

  assign level_nxt = (is_cm && tif.match_a && act == timer_pkg::ACT_LOW) ? 1'b0 :
                     (is_cm && tif.match_a && act == timer_pkg::ACT_HIGH) ? 1'b1 :
                     (is_cm && tif.match_a && act == timer_pkg::ACT_TOG) ? !level_r :
                     level_r;

  assign duty = swap ? timer_pkg::scaled_p(cp_r) : {1'b0, ca};
  // duty past the period never ends
  assign pwm_on = (act == timer_pkg::ACT_ACT) ? 1'b1 :
                  (act == timer_pkg::ACT_INACT) ? 1'b0 :
                  ({1'b0, tif.cnt} < duty);
  assign pwm_lvl = pwm_on ? ocl : !ocl;
  assign pin_nxt = (rise ? ocl : (is_pwm ? pwm_lvl : level_nxt)) ^ inv;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_r <= 1'b0;
      pin_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      level_r <= rise ? ocl : level_nxt;
      pin_r <= pin_nxt;
      oe_n_r <= !(is_cm || is_pwm);
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  logic [7:0] rd_byte;

  assign rd_byte =
    (addr_r == timer_pkg::OFS_CTRL0) ? {4'h0, en_r, 3'h0} :
    (addr_r == timer_pkg::OFS_CTRL1) ? ctrl1_r :
    (addr_r == timer_pkg::OFS_CNT_LO) ? tif.cnt[7:0] :
    (addr_r == timer_pkg::OFS_CNT_HI) ? tif.cnt[15:8] :
    (addr_r == timer_pkg::OFS_CA_LO) ? ca_lo_r :
    (addr_r == timer_pkg::OFS_CA_HI) ? ca_hi_r :
    (addr_r == timer_pkg::OFS_CP) ? cp_r :
    (addr_r == timer_pkg::OFS_FLAGS) ? {6'h00, flag_p_r, flag_a_r} :
    timer_pkg::RST_BYTE;

  // data is captured in the wait cycle and held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (state_r == ST_RDW) begin
      hrdata_r <= {24'h000000, rd_byte};
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign timer_output_pin = pin_r;
  assign pin_oe_n = oe_n_r;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_ca_write;
    wr_ca_lo |=> (tif.ca[7:0] == $past(hwdata[7:0]));
  endproperty
  a_ca_write: assert property (p_ca_write) else $error("compare-a low byte not stored");

  property p_p_clear;
    (tif.match_p && !tif.clr_a) |=> (tif.cnt == 16'h0000);
  endproperty
  a_p_clear: assert property (p_p_clear) else $error("p match did not clear counter");

  property p_no_p_flag;
    (!is_pwm && csel) |-> !set_p;
  endproperty
  a_no_p_flag: assert property (p_no_p_flag) else $error("p flag raised with a clear");

  property p_a_zero;
    (ca == 16'h0000) |-> !tif.match_a;
  endproperty
  a_a_zero: assert property (p_a_zero) else $error("a match with zero compare");

  property p_act_high;
    (is_cm && tif.match_a && act == timer_pkg::ACT_HIGH && !rise) |=> level_r;
  endproperty
  a_act_high: assert property (p_act_high) else $error("pin not driven high on a match");

  property p_init_level;
    (rise && is_cm) |=> (level_r == $past(ocl)) && (pin_r == ($past(ocl) ^ $past(inv)));
  endproperty
  a_init_level: assert property (p_init_level) else $error("initial level not loaded");

  property p_tc_release;
    (mode == timer_pkg::MODE_TC) |=> pin_oe_n;
  endproperty
  a_tc_release: assert property (p_tc_release) else $error("pin driven in timer mode");

  property p_forced_act;
    (is_pwm && act == timer_pkg::ACT_ACT) |=> (pin_r == ($past(ocl) ^ $past(inv)));
  endproperty
  a_forced_act: assert property (p_forced_act) else $error("forced active level wrong");

  property p_fall_hold;
    $fell(en_r) |=> (tif.cnt == $past(tif.cnt)) [*2];
  endproperty
  a_fall_hold: assert property (p_fall_hold) else $error("counter moved while off");

  property p_set_wins;
    (set_a && clr_fa) |=> flag_a_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("a flag lost on clear");

  c_cm_match: cover property (is_cm && tif.match_a && en_r);
  c_pwm_wrap: cover property (is_pwm && tif.match_p && !swap);
  c_swap_clear: cover property (is_pwm && swap && tif.match_a);
  c_read: cover property (state_r == ST_RDW ##1 state_r == ST_RDO);

endmodule
`default_nettype wire

// File: testbench/pin_load.sv
// partner model: the load on the timer output pin, counting its high cycles
`timescale 1ns/100ps
`default_nettype none
module pin_load (
  // clock
  input wire logic hclk,
  // pin from the block
  input wire logic pin,
  input wire logic pin_oe_n,
  // measurement window
  input wire logic meas,
  output logic lvl,
  output logic [15:0] high_cnt
);
  // ----------------------------------------
  // wire level and high-time counter
  // ----------------------------------------
  // a released pin is pulled up, so it never keeps showing the last driven level
  assign lvl = pin_oe_n ? 1'b1 : pin;
  // count only inside the window; closing it clears the count for the next case
  always_ff @(posedge hclk) begin
    if (!meas) begin
      high_cnt <= 16'h0000;
    end else if (lvl) begin
      high_cnt <= high_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the timer compare and pwm block
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic meas = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pin;
  logic pin_oe_n;
  logic lvl;
  logic [15:0] high_cnt;
  logic [31:0] rdata;
  logic [7:0] b;
  logic [7:0] r;
  logic o;
  logic [7:0] ofs [3];
  int error_cnt = 0;
  int n_compared = 0;

  // 125 MHz clock
  always #4 hclk = ~hclk;

  timer_cmp_pwm uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_output_pin(pin),
    .pin_oe_n(pin_oe_n));
  pin_load load (.hclk(hclk), .pin(pin), .pin_oe_n(pin_oe_n), .meas(meas), .lvl(lvl),
    .high_cnt(high_cnt));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ahb-lite single write; request held until hready is seen high
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    haddr <= {24'h000000, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  // ahb-lite single read; data taken at the edge that ends the data phase
  task automatic bus_rd(input logic [7:0] a);
    haddr <= {24'h000000, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdata = hrdata;
  endtask

  function automatic logic [7:0] ctl1(input logic [1:0] m, input logic [1:0] a,
    input logic oc, input logic inv, input logic sw, input logic cs);
    return {m, a, oc, inv, sw, cs};
  endfunction

  // pin after one compare-a match, from action code and initial level
  function automatic logic cm_pin(input logic [1:0] a, input logic oc);
    case (a)
      timer_pkg::ACT_LOW: return 1'b0;
      timer_pkg::ACT_HIGH: return 1'b1;
      timer_pkg::ACT_TOG: return ~oc;
      default: return oc;
    endcase
  endfunction

  // stop, program, clear flags, then a clean enable rise
  task automatic start(input logic [7:0] c1);
    bus_wr(timer_pkg::OFS_CTRL0, 8'h00);
    bus_wr(timer_pkg::OFS_CTRL1, c1);
    bus_wr(timer_pkg::OFS_FLAGS, 8'h03);
    bus_wr(timer_pkg::OFS_CTRL0, 8'h08);
  endtask

  // whole periods inside the window make the high count phase independent
  // the flags expected differ per case: a compare-a past the period never matches
  task automatic pwm_case(input logic [7:0] c1, input logic [15:0] ca, input int n,
    input int exp, input logic [31:0] fl);
    bus_wr(timer_pkg::OFS_CA_LO, ca[7:0]);
    bus_wr(timer_pkg::OFS_CA_HI, ca[15:8]);
    start(c1);
    repeat (600) @(posedge hclk);
    meas <= 1'b1;
    repeat (n) @(posedge hclk);
    meas <= 1'b0;
    #1;
    check("pwm_high", {16'h0000, high_cnt}, 32'(exp));
    bus_rd(timer_pkg::OFS_FLAGS);
    check("pwm_flags", rdata, fl);
  endtask

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    repeat (40000) @(posedge hclk);
    error_cnt++;
    summarize();
  end

  initial begin
    void'($urandom(83));
    ofs[0] = timer_pkg::OFS_CA_LO;
    ofs[1] = timer_pkg::OFS_CA_HI;
    ofs[2] = timer_pkg::OFS_CP;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int k = 0; k < 3; k++) begin
      bus_rd(ofs[k]);
      check("reg_reset", rdata, 32'h0);
      b = 8'($urandom);
      bus_wr(ofs[k], b);
      bus_rd(ofs[k]);
      check("reg_rw", rdata, {24'h000000, b});
    end
    bus_wr(8'h20, 8'h5a);
    bus_rd(8'h20);
    check("unmapped", rdata, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    // compare-a stays nonzero in compare mode
    bus_wr(timer_pkg::OFS_CA_HI, 8'h00);
    bus_wr(timer_pkg::OFS_CA_LO, 8'd100);
    bus_wr(timer_pkg::OFS_CP, 8'h01);
    for (int a = 0; a < 4; a++) begin
      o = 1'($urandom);
      start(ctl1(timer_pkg::MODE_CM, 2'(a), o, 1'b0, 1'b0, 1'b0));
      repeat (4) @(posedge hclk);
      check("pin_init", {31'h0, lvl}, {31'h0, o});
      // clear of the a flag lands in the a match cycle: the set must survive it
      repeat (95) @(posedge hclk);
      bus_wr(timer_pkg::OFS_FLAGS, 8'h01);
      repeat (53) @(posedge hclk);
      check("pin_match", {31'h0, lvl}, {31'h0, cm_pin(2'(a), o)});
      repeat (150) @(posedge hclk);
      check("pin_p_match", {31'h0, lvl}, {31'h0, cm_pin(2'(a), o)});
      bus_rd(timer_pkg::OFS_FLAGS);
      check("cm_flags", rdata, 32'h3);
      bus_rd(timer_pkg::OFS_CNT_HI);
      check("p_clear", rdata, 32'h0);
    end
    // compare-a at 456 lies above the p match at 256, so p matches do occur
    bus_wr(timer_pkg::OFS_CA_HI, 8'h01);
    bus_wr(timer_pkg::OFS_CA_LO, 8'd200);
    start(ctl1(timer_pkg::MODE_CM, timer_pkg::ACT_TOG, 1'b0, 1'b0, 1'b0, 1'b1));
    repeat (700) @(posedge hclk);
    bus_rd(timer_pkg::OFS_FLAGS);
    check("a_clear_flags", rdata, 32'h1);
    bus_rd(timer_pkg::OFS_CNT_HI);
    b = rdata[7:0];
    bus_rd(timer_pkg::OFS_CNT_LO);
    check("a_clear_cnt", {31'h0, {b, rdata[7:0]} < 16'd456}, 32'h1);
    // timer mode with compare-a zero
    bus_wr(timer_pkg::OFS_CA_HI, 8'h00);
    bus_wr(timer_pkg::OFS_CA_LO, 8'h00);
    start(ctl1(timer_pkg::MODE_TC, timer_pkg::ACT_TOG, 1'b1, 1'b0, 1'b0, 1'b0));
    repeat (600) @(posedge hclk);
    check("tc_release", {31'h0, pin_oe_n}, 32'h1);
    bus_rd(timer_pkg::OFS_FLAGS);
    check("tc_flags", rdata, 32'h2);
    // counter holds on disable, zeroes on the next rise
    bus_wr(timer_pkg::OFS_CTRL0, 8'h00);
    bus_rd(timer_pkg::OFS_CNT_LO);
    b = rdata[7:0];
    repeat (20) @(posedge hclk);
    bus_rd(timer_pkg::OFS_CNT_LO);
    check("cnt_hold", rdata, {24'h000000, b});
    bus_wr(timer_pkg::OFS_CTRL0, 8'h08);
    bus_rd(timer_pkg::OFS_CNT_LO);
    check("cnt_zeroed", {31'h0, rdata < 32'd20}, 32'h1);
    // pwm needs mode 10 together with action 10 or 11
    bus_wr(timer_pkg::OFS_CP, 8'h01);
    r = 8'd1 + 8'($urandom % 255);
    pwm_case(ctl1(timer_pkg::MODE_PWM, timer_pkg::ACT_PWM, 1'b1, 1'b0, 1'b0, 1'b1),
      {8'h00, r}, 512, 2 * int'(r), 32'h3);
    // duty past the period: the counter clears before compare-a can match
    pwm_case(ctl1(timer_pkg::MODE_PWM, timer_pkg::ACT_PWM, 1'b1, 1'b0, 1'b0, 1'b0),
      16'd300, 512, 512, 32'h2);
    pwm_case(ctl1(timer_pkg::MODE_PWM, timer_pkg::ACT_PWM, 1'b1, 1'b1, 1'b0, 1'b0),
      {8'h00, r}, 512, 512 - 2 * int'(r), 32'h3);
    pwm_case(ctl1(timer_pkg::MODE_PWM, timer_pkg::ACT_PWM, 1'b0, 1'b0, 1'b0, 1'b0),
      {8'h00, r}, 512, 512 - 2 * int'(r), 32'h3);
    pwm_case(ctl1(timer_pkg::MODE_PWM, timer_pkg::ACT_PWM, 1'b1, 1'b0, 1'b1, 1'b0),
      16'd1000, 2000, 512, 32'h3);
    pwm_case(ctl1(timer_pkg::MODE_PWM, timer_pkg::ACT_INACT, 1'b1, 1'b0, 1'b0, 1'b0),
      {8'h00, r}, 512, 0, 32'h3);
    pwm_case(ctl1(timer_pkg::MODE_PWM, timer_pkg::ACT_ACT, 1'b1, 1'b0, 1'b0, 1'b0),
      {8'h00, r}, 512, 512, 32'h3);
    summarize();
  end
endmodule
`default_nettype wire
